// >>> core/opmode_pkg.sv
// ****************************************************************
// Constants shared by the operating-mode control.
// ****************************************************************
package opmode_pkg;

   // Operating modes presented to decode and address generation.
   typedef enum logic [2:0]
   {
      MODE_REAL,
      MODE_PROTECTED,
      MODE_VIRTUAL,
      MODE_SYS_MGMT,
      MODE_LONG64,
      MODE_COMPAT
   } mode_type;

   // Size encodings for address, operand and stack widths.
   localparam logic [1:0] SIZE_16 = 2'h0;
   localparam logic [1:0] SIZE_32 = 2'h1;
   localparam logic [1:0] SIZE_64 = 2'h2;

   // Register widths in bits.
   localparam logic [6:0] REG_WIDTH_32 = 7'h20;
   localparam logic [6:0] REG_WIDTH_64 = 7'h40;

   // Address-space limits expressed as number of address bits.
   localparam logic [6:0] SPACE_BITS_REAL = 7'h14;
   localparam logic [6:0] SPACE_BITS_4G = 7'h20;
   localparam logic [6:0] SPACE_BITS_64 = 7'h40;

   // Privilege levels.
   localparam logic [1:0] PRIV_KERNEL = 2'h0;
   localparam logic [1:0] PRIV_USER = 2'h3;

   // Reset values of the mode state.
   localparam logic RESET_FLAG = 1'b0;

endpackage : opmode_pkg

// >>> core/opmode_ctrl.sv
// Operation
// - Reset or power-up always starts the core in real mode.
// - 64-bit submode defaults to 64-bit address, 32-bit operand size.
// - 64-bit submode prefixes override one instruction; extension prefix gives 64-bit operands.
// - 64-bit submode: 64-bit registers, extra general and vector registers only there.
// - Long submode chosen per code segment from its attributes.
// - Compatibility submode confines accesses to the lowest 4 Gbytes.
// - Compatibility submode: size prefixes toggle 16 and 32-bit sizes.
// - Compatibility: protected segmentation, long-mode translation and interrupts.
// - Long mode only with paged protected mode; no real mode then.
// - Real mode: 1 Mbyte space, 16-bit operands, prefix gives 32.
// - Real mode: no paging, all software at privilege 0.
// - Protected mode: 4 Gbyte spaces, physical equals virtual unpaged.
// - Protected mode supports privilege levels zero through 3.
// - Virtual mode: privilege 3 task, real-mode translation, 1 Mbyte space.
// - Virtual mode follows the flag, changed only by task switch or return; the code also clears it with protection off or long mode enabled.
// - Pop-flags leaves the virtual-machine flag unchanged.
// - With long mode enabled, virtual mode enable is silently ignored.
// - System-management interrupt enters system-management mode, separate space.
// - System-management output isolates handler memory while active.
// - System-management mode: real addressing, 4 Gbyte limits, 16-bit defaults.
`timescale 1ns/1ps
module opmode_ctrl
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // System control bits from privileged software.
   input wire logic protect_enable,
   input wire logic paging_enable,
   input wire logic long_enable,
   // Code-segment attributes of the current code segment.
   input wire logic cs_long_attr,
   input wire logic cs_default_big,
   input wire logic [1:0] cs_privilege,
   // Flag-load events.
   input wire logic flags_load_task_switch,
   input wire logic flags_load_interrupt_return,
   input wire logic flags_load_pop,
   input wire logic flags_load_vm,
   // System-management entry and resume.
   input wire logic system_mgmt_interrupt,
   input wire logic system_mgmt_resume,
   // Per-instruction prefixes.
   input wire logic operand_size_prefix,
   input wire logic address_size_prefix,
   input wire logic register_extension_prefix,
   // Mode state outputs.
   output opmode_pkg::mode_type mode,
   output logic virtual_machine_flag,
   output logic system_mgmt_mode,
   output logic long_active,
   // Size and feature outputs for the current instruction.
   output logic [1:0] address_size,
   output logic [1:0] operand_size,
   output logic [1:0] stack_size,
   output logic [6:0] general_register_width,
   output logic extra_registers_enable,
   output logic [6:0] virtual_space_bits,
   output logic paging_active,
   output logic segmentation_legacy,
   output logic long_translation,
   output logic [1:0] current_privilege
);
   import opmode_pkg::*;

   // ****************************************************************
   // Mode state.
   // ****************************************************************
   logic sys_mgmt_saved_long;
   mode_type next_mode;
   logic next_vm;
   logic next_sys_mgmt;
   logic long_legal;
   logic vm_write;

   // Long mode is legal only under paged protected mode.
   assign long_legal = long_enable & protect_enable & paging_enable;
   // Only task switch or privileged return may write the flag; pop-flags cannot.
   assign vm_write = (flags_load_task_switch | (flags_load_interrupt_return
      & (cs_privilege == PRIV_KERNEL))) & ~flags_load_pop;
   // Set requests are dropped silently while long mode is enabled.
   assign next_vm = vm_write ? (flags_load_vm & ~long_enable) :
      (virtual_machine_flag & protect_enable & ~long_enable);
   // Interrupt entry wins over resume.
   assign next_sys_mgmt = system_mgmt_interrupt | (system_mgmt_mode & ~system_mgmt_resume);

   // Mode selection from the next flag values and the segment attributes.
   always_comb
   begin
      next_mode = MODE_REAL;
      if (next_sys_mgmt)
         next_mode = MODE_SYS_MGMT;
      else if (long_legal)
         next_mode = cs_long_attr ? MODE_LONG64 : MODE_COMPAT;
      else if (protect_enable & next_vm)
         next_mode = MODE_VIRTUAL;
      else if (protect_enable)
         next_mode = MODE_PROTECTED;
      else
         next_mode = MODE_REAL;
   end

   // State registers; reset forces real mode.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode <= MODE_REAL;
         virtual_machine_flag <= RESET_FLAG;
         system_mgmt_mode <= RESET_FLAG;
      end
      else
      begin
         mode <= next_mode;
         virtual_machine_flag <= next_vm;
         system_mgmt_mode <= next_sys_mgmt;
      end
   end

   // Remember whether long mode was active on system-management entry.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sys_mgmt_saved_long <= RESET_FLAG;
      else if (system_mgmt_interrupt & ~system_mgmt_mode)
         sys_mgmt_saved_long <= long_legal;
   end

   // ****************************************************************
   // Decoded attributes of the current mode.
   // ****************************************************************
   logic is_long64;
   logic is_compat;
   logic is_real_addr;
   logic [1:0] legacy_default;
   logic [1:0] legacy_toggled_op;
   logic [1:0] legacy_toggled_addr;

   assign is_long64 = (mode == MODE_LONG64);
   assign is_compat = (mode == MODE_COMPAT);
   assign is_real_addr = (mode == MODE_REAL) | (mode == MODE_VIRTUAL) | (mode == MODE_SYS_MGMT);
   assign long_active = is_long64 | is_compat;
   // Protected and compatibility defaults follow the segment size bit.
   assign legacy_default = (cs_default_big & ~is_real_addr) ? SIZE_32 : SIZE_16;
   // A size prefix toggles between 16 and 32 bits.
   assign legacy_toggled_op = operand_size_prefix ?
      ((legacy_default == SIZE_32) ? SIZE_16 : SIZE_32) : legacy_default;
   assign legacy_toggled_addr = address_size_prefix ?
      ((legacy_default == SIZE_32) ? SIZE_16 : SIZE_32) : legacy_default;

   // Address size: 64 by default in 64-bit submode, prefix gives 32.
   always_comb
   begin
      if (is_long64)
         address_size = address_size_prefix ? SIZE_32 : SIZE_64;
      else
         address_size = legacy_toggled_addr;
   end

   // Operand size: 32 by default in 64-bit submode, extension prefix gives 64.
   always_comb
   begin
      if (is_long64)
      begin
         if (register_extension_prefix)
            operand_size = SIZE_64;
         else if (operand_size_prefix)
            operand_size = SIZE_16;
         else
            operand_size = SIZE_32;
      end
      else
         operand_size = legacy_toggled_op;
   end

   // Stack size follows 64 bits in 64-bit submode, else the segment default.
   assign stack_size = is_long64 ? SIZE_64 : legacy_default;
   assign general_register_width = is_long64 ? REG_WIDTH_64 : REG_WIDTH_32;
   assign extra_registers_enable = is_long64 & register_extension_prefix;

   // Virtual-space reach for each mode.
   always_comb
   begin
      case (mode)
         MODE_LONG64: virtual_space_bits = SPACE_BITS_64;
         MODE_COMPAT: virtual_space_bits = SPACE_BITS_4G;
         MODE_PROTECTED: virtual_space_bits = SPACE_BITS_4G;
         MODE_SYS_MGMT: virtual_space_bits = SPACE_BITS_4G;
         MODE_VIRTUAL: virtual_space_bits = SPACE_BITS_REAL;
         MODE_REAL: virtual_space_bits = SPACE_BITS_REAL;
         default: virtual_space_bits = SPACE_BITS_REAL;
      endcase
   end

   // Paging off in real and system-management modes; identity map unpaged.
   assign paging_active = paging_enable & protect_enable & (mode != MODE_REAL)
      & (mode != MODE_SYS_MGMT);
   assign segmentation_legacy = ~is_long64;
   assign long_translation = long_active | (system_mgmt_mode & sys_mgmt_saved_long);

   // Privilege: 0 in real and system-management modes, 3 in virtual mode, segment level otherwise.
   always_comb
   begin
      case (mode)
         MODE_REAL: current_privilege = PRIV_KERNEL;
         MODE_SYS_MGMT: current_privilege = PRIV_KERNEL;
         MODE_VIRTUAL: current_privilege = PRIV_USER;
         default: current_privilege = cs_privilege;
      endcase
   end

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_reset_real_mode: assert property ($rose(rst_n) |-> mode == MODE_REAL)
      else $error("Mode not real after reset.");
   a_long_sizes: assert property (is_long64 && !address_size_prefix && !operand_size_prefix
      && !register_extension_prefix |-> address_size == SIZE_64 && operand_size == SIZE_32)
      else $error("Wrong 64-bit defaults.");
   a_ext_prefix_size: assert property (is_long64 && register_extension_prefix
      |-> operand_size == SIZE_64 && extra_registers_enable)
      else $error("Extension prefix not honoured.");
   a_extra_regs_only: assert property (extra_registers_enable |-> is_long64
      && general_register_width == REG_WIDTH_64)
      else $error("Extra registers outside 64-bit submode.");
   a_segment_submode: assert property (!next_sys_mgmt && long_legal
      |=> mode == ($past(cs_long_attr) ? MODE_LONG64 : MODE_COMPAT))
      else $error("Submode not from code segment.");
   a_compat_space: assert property (is_compat |-> virtual_space_bits == SPACE_BITS_4G)
      else $error("Compatibility space not 4 Gbytes.");
   a_compat_toggle: assert property (is_compat && address_size_prefix
      |-> address_size != legacy_default && address_size != SIZE_64)
      else $error("Compatibility prefix toggle wrong.");
   a_long_paged: assert property (long_active |-> $past(protect_enable && paging_enable))
      else $error("Long mode without paged protection.");
   a_real_priv: assert property (mode == MODE_REAL |-> current_privilege == PRIV_KERNEL
      && !paging_active && operand_size != SIZE_64)
      else $error("Real mode privilege or paging wrong.");
   a_vm_pop_hold: assert property (flags_load_pop && !system_mgmt_interrupt && protect_enable
      && !long_enable |=> virtual_machine_flag == $past(virtual_machine_flag))
      else $error("Pop-flags changed the flag.");
   a_vm_long_ignored: assert property (long_enable |=> !virtual_machine_flag)
      else $error("Virtual mode set under long mode.");
   a_sys_mgmt_entry: assert property (system_mgmt_interrupt |=> system_mgmt_mode
      && mode == MODE_SYS_MGMT && virtual_space_bits == SPACE_BITS_4G)
      else $error("System-management entry failed.");

   // ****************************************************************
   // Assertions on the attributes of each mode.
   // ****************************************************************

   // Real mode reaches one megabyte and a prefix widens operands to 32 bits.
   a_real_space: assert property (mode == MODE_REAL |->
      virtual_space_bits == SPACE_BITS_REAL && operand_size == (operand_size_prefix ? SIZE_32 : SIZE_16))
      else $error("Real mode space or operand size wrong.");

   // Protected mode reaches 4 Gbytes and pages only when paging is on.
   a_protect_space: assert property (mode == MODE_PROTECTED |->
      virtual_space_bits == SPACE_BITS_4G && paging_active == (paging_enable && protect_enable))
      else $error("Protected mode space or paging wrong.");

   // Protected mode takes the privilege level of the code segment.
   a_protect_priv: assert property (mode == MODE_PROTECTED |->
      current_privilege == cs_privilege)
      else $error("Protected mode privilege wrong.");

   // Virtual mode runs at privilege 3 over a one-megabyte space.
   a_virtual_task: assert property (mode == MODE_VIRTUAL |-> current_privilege == PRIV_USER
      && virtual_space_bits == SPACE_BITS_REAL && virtual_machine_flag)
      else $error("Virtual mode attributes wrong.");

   // The flag moves only on a permitted load, when protection drops or while long mode is enabled.
   a_vm_write_only: assert property ($changed(virtual_machine_flag) |->
      $past(vm_write || !protect_enable || long_enable))
      else $error("Flag changed without a permitted load.");

   // A return from an unprivileged level leaves the flag alone.
   a_interrupt_return_instr_user_ignored: assert property (flags_load_interrupt_return && !flags_load_task_switch
      && cs_privilege != PRIV_KERNEL && protect_enable && !long_enable |=> virtual_machine_flag == $past(virtual_machine_flag))
      else $error("Unprivileged return changed the flag.");

   // The flag is never set while long mode is active.
   a_long_no_virtual: assert property (long_active |->
      !virtual_machine_flag)
      else $error("Flag set in long mode.");

   // System-management defaults are 16 bits for every size.
   a_sys_mgmt_sizes: assert property (mode == MODE_SYS_MGMT && !operand_size_prefix
      && !address_size_prefix |-> operand_size == SIZE_16 && address_size == SIZE_16 && stack_size == SIZE_16)
      else $error("System-management default sizes wrong.");

   // The isolation output stands only while the mode is active, and paging is then off.
   a_sys_mgmt_output: assert property (system_mgmt_mode |->
      mode == MODE_SYS_MGMT && !paging_active)
      else $error("System-management output without the mode.");

   // A resume without a new interrupt leaves system-management mode.
   a_resume_exit: assert property (system_mgmt_mode && system_mgmt_resume && !system_mgmt_interrupt
      |=> !system_mgmt_mode && mode != MODE_SYS_MGMT)
      else $error("Resume did not leave system-management mode.");

   // Compatibility submode keeps legacy segments and long translation.
   a_compat_legacy: assert property (is_compat |->
      segmentation_legacy && long_translation)
      else $error("Compatibility segmentation or translation wrong.");

   // The operand prefix toggles 16 and 32 bits in compatibility submode.
   a_compat_op_toggle: assert property (is_compat && operand_size_prefix
      |-> operand_size != legacy_default && operand_size != SIZE_64)
      else $error("Compatibility operand toggle wrong.");

   // Outside 64-bit submode registers stay narrow and the extras are hidden.
   a_narrow_registers: assert property (!is_long64 |->
      general_register_width == REG_WIDTH_32 && !extra_registers_enable)
      else $error("Wide registers outside 64-bit submode.");

   // The 64-bit submode uses a flat 64-bit space and a 64-bit stack.
   a_long64_flat: assert property (is_long64 |-> stack_size == SIZE_64
      && !segmentation_legacy && virtual_space_bits == SPACE_BITS_64)
      else $error("64-bit submode attributes wrong.");

   // The address prefix narrows addresses to 32 bits in 64-bit submode.
   a_long64_addr_prefix: assert property (is_long64 && address_size_prefix |->
      address_size == SIZE_32)
      else $error("64-bit address prefix wrong.");

   // Real mode never shows long mode or system management.
   a_real_no_long: assert property (mode == MODE_REAL |->
      !long_active && !long_translation && !system_mgmt_mode)
      else $error("Long state visible in real mode.");

   c_enter_long64: cover property (mode == MODE_PROTECTED ##1 mode == MODE_LONG64);
   c_enter_virtual: cover property (mode == MODE_PROTECTED ##1 mode == MODE_VIRTUAL);
   c_sys_mgmt_round: cover property (system_mgmt_interrupt ##[1:20] system_mgmt_resume);
   c_compat_mode: cover property (mode == MODE_COMPAT);
   // System management entered straight from 64-bit submode.
   c_sys_mgmt_from_long: cover property (mode == MODE_LONG64 ##1 mode == MODE_SYS_MGMT);

endmodule : opmode_ctrl

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import opmode_pkg::*;
   // ****************************************************************
   // Stimulus, expectation queue and counters.
   // ****************************************************************
   typedef struct packed
   {
      mode_type m;
      logic [1:0] a;
      logic [1:0] o;
      logic [1:0] p;
      logic s;
      logic x;
      logic [6:0] w;
      logic [1:0] k;
      logic t;
   } expect_type;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic protect_enable = 1'b0, paging_enable = 1'b0, long_enable = 1'b0;
   logic cs_long_attr = 1'b0, cs_default_big = 1'b0;
   logic [1:0] cs_privilege = 2'h0;
   logic flags_load_task_switch = 1'b0, flags_load_interrupt_return = 1'b0;
   logic flags_load_pop = 1'b0, flags_load_vm = 1'b0;
   logic system_mgmt_interrupt = 1'b0, system_mgmt_resume = 1'b0;
   logic operand_size_prefix = 1'b0, address_size_prefix = 1'b0;
   logic register_extension_prefix = 1'b0;
   mode_type mode;
   logic virtual_machine_flag, system_mgmt_mode, long_active, extra_registers_enable;
   logic [1:0] address_size, operand_size, stack_size, current_privilege;
   logic [6:0] general_register_width, virtual_space_bits;
   logic paging_active, segmentation_legacy, long_translation;
   expect_type exp_q[$];
   expect_type got;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   integer seed = 32'hF86AC8E3;
   int i;

   opmode_ctrl u_dut
   (
      .clk(clk), .rst_n(rst_n), .protect_enable(protect_enable),
      .paging_enable(paging_enable), .long_enable(long_enable), .cs_long_attr(cs_long_attr),
      .cs_default_big(cs_default_big), .cs_privilege(cs_privilege),
      .flags_load_task_switch(flags_load_task_switch),
      .flags_load_interrupt_return(flags_load_interrupt_return),
      .flags_load_pop(flags_load_pop), .flags_load_vm(flags_load_vm),
      .system_mgmt_interrupt(system_mgmt_interrupt), .system_mgmt_resume(system_mgmt_resume),
      .operand_size_prefix(operand_size_prefix), .address_size_prefix(address_size_prefix),
      .register_extension_prefix(register_extension_prefix), .mode(mode),
      .virtual_machine_flag(virtual_machine_flag), .system_mgmt_mode(system_mgmt_mode),
      .long_active(long_active), .address_size(address_size), .operand_size(operand_size),
      .stack_size(stack_size), .general_register_width(general_register_width),
      .extra_registers_enable(extra_registers_enable), .virtual_space_bits(virtual_space_bits),
      .paging_active(paging_active), .segmentation_legacy(segmentation_legacy),
      .long_translation(long_translation), .current_privilege(current_privilege)
   );

   // The clock toggles every half period of 2.5 ns.
   always #2.5 clk = ~clk;

   // ****************************************************************
   // Checking and closing.
   // ****************************************************************
   task check(input logic [15:0] seen, input logic [15:0] expv);
      total_checks++;
      if (seen !== expv)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : check

   task test_done;
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   // The watcher takes the oldest note after each rising edge and compares the outputs.
   always @(posedge clk)
   begin
      #1;
      if (exp_q.size() > 0)
      begin
         got = exp_q.pop_front();
         check(mode, got.m);
         check(address_size, got.a);
         check(operand_size, got.o);
         check(current_privilege, got.p);
         check(system_mgmt_mode, got.s);
         check(extra_registers_enable, got.x);
         check(general_register_width, got.w);
         if (got.m == MODE_REAL)
            check(paging_active, 1'b0);
         check(stack_size, got.k);
         check(long_translation, got.t);
         check(long_active, got.m inside {MODE_LONG64, MODE_COMPAT});
         check(segmentation_legacy, got.m != MODE_LONG64);
         check(virtual_machine_flag, got.m == MODE_VIRTUAL);
         check(paging_active, paging_enable && protect_enable
            && !(got.m inside {MODE_REAL, MODE_SYS_MGMT}));
         check(virtual_space_bits, (got.m == MODE_LONG64) ? SPACE_BITS_64
            : (got.m inside {MODE_REAL, MODE_VIRTUAL}) ? SPACE_BITS_REAL : SPACE_BITS_4G);
      end
   end

   // A cycle ceiling cuts a hung run short.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         bad_count++;
         test_done();
      end
   end

   // ****************************************************************
   // One cycle of stimulus with its expected outcome.
   // ****************************************************************
   task step(input logic [4:0] ev, input logic vm, input logic [1:0] pr, input mode_type m);
      expect_type e;
      logic ap, op, rx;
      logic [1:0] b;
      ap = $random(seed);
      op = $random(seed);
      rx = $random(seed);
      cs_default_big = $random(seed);
      {system_mgmt_interrupt, system_mgmt_resume, flags_load_task_switch} = ev[4:2];
      {flags_load_interrupt_return, flags_load_pop} = ev[1:0];
      flags_load_vm = vm;
      cs_privilege = pr;
      address_size_prefix = ap;
      operand_size_prefix = op;
      register_extension_prefix = rx;
      b = cs_default_big ? SIZE_32 : SIZE_16;
      e.m = m;
      e.s = (m == MODE_SYS_MGMT);
      e.x = (m == MODE_LONG64) && rx;
      e.w = (m == MODE_LONG64) ? REG_WIDTH_64 : REG_WIDTH_32;
      e.p = (m == MODE_VIRTUAL) ? PRIV_USER
         : (m inside {MODE_REAL, MODE_SYS_MGMT}) ? PRIV_KERNEL : pr;
      e.k = (m == MODE_LONG64) ? SIZE_64 : (m inside {MODE_PROTECTED, MODE_COMPAT}) ? b : SIZE_16;
      e.t = (m inside {MODE_LONG64, MODE_COMPAT}) || (m == MODE_SYS_MGMT && long_enable);
      if (m == MODE_LONG64)
      begin
         e.a = ap ? SIZE_32 : SIZE_64;
         e.o = rx ? SIZE_64 : (op ? SIZE_16 : SIZE_32);
      end
      else if (m inside {MODE_PROTECTED, MODE_COMPAT})
      begin
         e.a = b ^ {1'b0, ap};
         e.o = b ^ {1'b0, op};
      end
      else
      begin
         e.a = {1'b0, ap};
         e.o = {1'b0, op};
      end
      exp_q.push_back(e);
      @(negedge clk);
   endtask : step

   // The main sequence walks the modes and their transitions.
   initial
   begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      step(5'h00, 1'b0, 2'h2, MODE_REAL);
      protect_enable = 1'b1;
      for (i = 0; i < 5; i++)
         step(5'h00, 1'b0, 2'($random(seed)), MODE_PROTECTED);
      paging_enable = 1'b1;
      step(5'h04, 1'b1, 2'h0, MODE_VIRTUAL);
      step(5'h01, 1'b0, 2'h0, MODE_VIRTUAL);
      step(5'h02, 1'b0, 2'h3, MODE_VIRTUAL);
      step(5'h02, 1'b0, 2'h0, MODE_PROTECTED);
      step(5'h02, 1'b1, 2'h3, MODE_PROTECTED);
      step(5'h10, 1'b0, 2'h1, MODE_SYS_MGMT);
      step(5'h00, 1'b0, 2'h2, MODE_SYS_MGMT);
      step(5'h08, 1'b0, 2'h2, MODE_PROTECTED);
      step(5'h18, 1'b0, 2'h0, MODE_SYS_MGMT);
      step(5'h08, 1'b0, 2'h0, MODE_PROTECTED);
      long_enable = 1'b1;
      cs_long_attr = 1'b1;
      for (i = 0; i < 6; i++)
         step(5'h00, 1'b0, 2'($random(seed)), MODE_LONG64);
      cs_long_attr = 1'b0;
      for (i = 0; i < 4; i++)
         step(5'h00, 1'b0, 2'($random(seed)), MODE_COMPAT);
      cs_long_attr = 1'b1;
      step(5'h04, 1'b1, 2'h0, MODE_LONG64);
      step(5'h02, 1'b1, 2'h0, MODE_LONG64);
      step(5'h10, 1'b0, 2'h0, MODE_SYS_MGMT);
      step(5'h08, 1'b0, 2'h0, MODE_LONG64);
      rst_n = 1'b0;
      {protect_enable, paging_enable, long_enable, cs_long_attr} = 4'h0;
      step(5'h00, 1'b0, 2'h0, MODE_REAL);
      rst_n = 1'b1;
      step(5'h00, 1'b0, 2'h1, MODE_REAL);
      @(negedge clk);
      test_done();
   end
endmodule : testbench
